// ===== design/drm_ring_node.sv
// Ring status messaging node with APB registers
// Operation
// - Dual channel: own messages leave on both channels together.
// - Single channel: own messages leave on channel one only.
// - Forward received messages not originated by this node; one arriving at a full forward slot is dropped.
// - Send an integrity message at least every 1000 ms.
// - A changed state is queued at once, sent when all channels in use are free.
// - Ring mode: own message not returned in time flags ring break.
// - One offline flag per peer, set when its messages stop.
// - Own sender identifier goes into every originated message.
// - Link rate is 64 or 128 kbps, same on all nodes.
// - The one selected rate drives both channels.
// - Per hop forwarding delay stays far below a fifth of a cycle.
// - Bridge enable copies channel one traffic onto channel two in dual channel mode.
`timescale 1ns/100ps
`default_nettype none
`include "drm_consts.svh"
module drm_ring_node #(
  parameter int MS_TICK_CYCLES = `DRM_MS_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic tx_ch1_o,
  output logic tx_ch2_o,
  input wire logic rx_ch1_i,
  input wire logic rx_ch2_i,
  output logic ring_break_o,
  output logic [`DRM_PEERS-1:0] peer_offline_o
);
  import drm_pkg::*;

  function automatic logic drm_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    drm_hit = (a[7:2] == off[7:2]);
  endfunction

  drm_top_st_t s_reg;
  drm_top_st_t s_next;
  logic apb_setup;
  logic apb_access;
  logic apb_mapped;
  logic apb_wr;
  logic tick;
  logic ms_tick;
  logic [7:0] div_max;
  logic own_go;
  drm_msg_t own_msg;
  logic [1:0] tx_load;
  logic [1:0] tx_ready;
  logic [1:0] tx_line;
  drm_msg_t tx_data [2];
  logic [1:0] rx_valid;
  logic [1:0] rx_line;
  drm_msg_t rx_data [2];
  logic [1:0] rx_own;
  logic [1:0] rx_peer;
  logic [`DRM_INT_W-1:0] ev;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign apb_setup = psel_i && !penable_i;
  assign apb_access = psel_i && penable_i;
  assign apb_mapped = drm_hit(paddr_i, `DRM_REG_CTRL) ||
                      drm_hit(paddr_i, `DRM_REG_TXST) ||
                      drm_hit(paddr_i, `DRM_REG_STAT) ||
                      drm_hit(paddr_i, `DRM_REG_INTS) ||
                      drm_hit(paddr_i, `DRM_REG_INTM) ||
                      drm_hit(paddr_i, `DRM_REG_RXL);
  assign apb_wr = apb_access && pwrite_i && apb_mapped;

  // ---------------------------------------------------------------
  // Bit rate and millisecond dividers
  // ---------------------------------------------------------------
  // One divider serves both channels
  assign div_max = s_reg.rate_hi ? 8'(`DRM_DIV_HI - 1) :
                                   8'(`DRM_DIV_LO - 1);
  assign tick = (s_reg.div_cnt >= div_max);
  assign ms_tick = (s_reg.ms_cnt >= 18'(MS_TICK_CYCLES - 1));

  // ---------------------------------------------------------------
  // Transmit arbitration
  // ---------------------------------------------------------------
  assign own_msg = {s_reg.id, s_reg.states, s_reg.seq};
  // Own message waits until all channels in use are free so they leave together
  assign own_go = s_reg.own_pend && s_reg.en && tx_ready[0] &&
                  (!s_reg.dual || tx_ready[1]);
  assign tx_load[0] = own_go || (s_reg.en && !s_reg.own_pend &&
                      tx_ready[0] && s_reg.fwd_full[0]);
  assign tx_load[1] = s_reg.dual && (own_go || (s_reg.en &&
                      !s_reg.own_pend && tx_ready[1] &&
                      s_reg.fwd_full[1]));
  assign tx_data[0] = own_go ? own_msg : s_reg.fwd_data[0];
  assign tx_data[1] = own_go ? own_msg : s_reg.fwd_data[1];
  assign rx_line[0] = rx_ch1_i;
  assign rx_line[1] = rx_ch2_i;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      drm_tx u_tx (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .load_i(tx_load[g]),
        .data_i(tx_data[g]),
        .ready_o(tx_ready[g]),
        .line_o(tx_line[g])
      );
      drm_rx u_rx (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .line_i(rx_line[g]),
        .valid_o(rx_valid[g]),
        .data_o(rx_data[g])
      );
      assign rx_own[g] = rx_valid[g] && s_reg.en &&
                         (g == 0 || s_reg.dual) &&
                         rx_data[g][`DRM_ID_LSB +: `DRM_ID_W] == s_reg.id;
      assign rx_peer[g] = rx_valid[g] && s_reg.en &&
                          (g == 0 || s_reg.dual) &&
                          rx_data[g][`DRM_ID_LSB +: `DRM_ID_W] != s_reg.id;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    ev = '0;
    s_next.div_cnt = tick ? 8'h00 : s_reg.div_cnt + 8'h01;
    s_next.ms_cnt = ms_tick ? 18'h00000 : s_reg.ms_cnt + 18'h00001;
    // Integrity timer
    if (own_go) begin
      s_next.own_pend = 1'b0;
      s_next.integ_ms = '0;
      s_next.seq = s_reg.seq + 4'h1;
    end else if (ms_tick) begin
      if (s_reg.integ_ms >= 10'(`DRM_INTEGRITY_MS - 1)) begin
        s_next.own_pend = 1'b1;
      end else begin
        s_next.integ_ms = s_reg.integ_ms + 10'h001;
      end
    end
    // Return watchdog
    if (ms_tick && s_reg.ret_wait) begin
      s_next.ret_ms = s_reg.ret_ms + 8'h01;
      if (s_reg.ret_ms >= 8'(`DRM_RETURN_MS - 1)) begin
        s_next.ret_wait = 1'b0;
        s_next.ring_break = 1'b1;
        ev[`DRM_INT_RING] = !s_reg.ring_break;
      end
    end
    if (rx_own != 2'b00) begin
      s_next.ret_wait = 1'b0;
      s_next.ring_break = 1'b0;
    end
    if (own_go && s_reg.ring) begin
      s_next.ret_wait = 1'b1;
      s_next.ret_ms = '0;
    end
    // Peer ageing; own identifier is never a peer
    for (int i = 0; i < `DRM_PEERS; i++) begin
      if (i == int'(s_reg.id)) begin
        s_next.off_ms[i] = '0;
        s_next.offline[i] = 1'b0;
      end else if (ms_tick) begin
        if (s_reg.off_ms[i] >= 12'(`DRM_OFFLINE_MS - 1)) begin
          s_next.offline[i] = 1'b1;
          ev[`DRM_INT_OFF] = ev[`DRM_INT_OFF] | !s_reg.offline[i];
        end else begin
          s_next.off_ms[i] = s_reg.off_ms[i] + 12'h001;
        end
      end
    end
    // Forward slots
    for (int k = 0; k < 2; k++) begin
      if (tx_load[k] && !own_go) begin
        s_next.fwd_full[k] = 1'b0;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (rx_peer[k]) begin
        s_next.off_ms[rx_data[k][`DRM_ID_LSB +: `DRM_ID_W]] = '0;
        s_next.offline[rx_data[k][`DRM_ID_LSB +: `DRM_ID_W]] = 1'b0;
        s_next.rx_last = rx_data[k];
        ev[`DRM_INT_MSG] = 1'b1;
        for (int j = 0; j < 2; j++) begin
          if (j == k || (k == 0 && s_reg.bridge && s_reg.dual)) begin
            if (s_next.fwd_full[j]) begin
              ev[`DRM_INT_DROP] = 1'b1;
            end else begin
              s_next.fwd_full[j] = 1'b1;
              s_next.fwd_data[j] = rx_data[k];
            end
          end
        end
      end
    end
    // Register writes
    if (apb_wr && drm_hit(paddr_i, `DRM_REG_CTRL)) begin
      s_next.en = pwdata_i[`DRM_CTRL_EN];
      s_next.dual = pwdata_i[`DRM_CTRL_DUAL];
      s_next.ring = pwdata_i[`DRM_CTRL_RING];
      s_next.rate_hi = pwdata_i[`DRM_CTRL_RATE];
      s_next.bridge = pwdata_i[`DRM_CTRL_BRIDGE];
      s_next.id = pwdata_i[`DRM_CTRL_ID_LSB +: `DRM_ID_W];
    end
    if (apb_wr && drm_hit(paddr_i, `DRM_REG_TXST)) begin
      s_next.states = pwdata_i[`DRM_ST_W-1:0];
      if (pwdata_i[`DRM_ST_W-1:0] != s_reg.states) begin
        s_next.own_pend = 1'b1;
      end
    end
    if (apb_wr && drm_hit(paddr_i, `DRM_REG_INTM)) begin
      s_next.int_mask = pwdata_i[`DRM_INT_W-1:0];
    end
    // Set wins over write-one-to-clear
    s_next.int_stat = s_reg.int_stat | ev;
    if (apb_wr && drm_hit(paddr_i, `DRM_REG_INTS)) begin
      s_next.int_stat = (s_reg.int_stat & ~pwdata_i[`DRM_INT_W-1:0]) | ev;
    end
    // Read data is captured in the setup phase
    if (apb_setup && !pwrite_i) begin
      s_next.prdata = 32'h00000000;
      if (drm_hit(paddr_i, `DRM_REG_CTRL)) begin
        s_next.prdata[`DRM_CTRL_EN] = s_reg.en;
        s_next.prdata[`DRM_CTRL_DUAL] = s_reg.dual;
        s_next.prdata[`DRM_CTRL_RING] = s_reg.ring;
        s_next.prdata[`DRM_CTRL_RATE] = s_reg.rate_hi;
        s_next.prdata[`DRM_CTRL_BRIDGE] = s_reg.bridge;
        s_next.prdata[`DRM_CTRL_ID_LSB +: `DRM_ID_W] = s_reg.id;
      end else if (drm_hit(paddr_i, `DRM_REG_TXST)) begin
        s_next.prdata[`DRM_ST_W-1:0] = s_reg.states;
      end else if (drm_hit(paddr_i, `DRM_REG_STAT)) begin
        s_next.prdata[`DRM_STAT_RING] = s_reg.ring_break;
        s_next.prdata[`DRM_STAT_OWNP] = s_reg.own_pend;
        s_next.prdata[`DRM_STAT_FWD_LSB +: 2] = s_reg.fwd_full;
        s_next.prdata[`DRM_STAT_OFF_LSB +: `DRM_PEERS] = s_reg.offline;
      end else if (drm_hit(paddr_i, `DRM_REG_INTS)) begin
        s_next.prdata[`DRM_INT_W-1:0] = s_reg.int_stat;
      end else if (drm_hit(paddr_i, `DRM_REG_INTM)) begin
        s_next.prdata[`DRM_INT_W-1:0] = s_reg.int_mask;
      end else if (drm_hit(paddr_i, `DRM_REG_RXL)) begin
        s_next.prdata[`DRM_MSG_W-1:0] = s_reg.rx_last;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.offline <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata_o = s_reg.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_access && !apb_mapped;
  assign irq_o = |(s_reg.int_stat & s_reg.int_mask);
  assign tx_ch1_o = tx_line[0];
  assign tx_ch2_o = tx_line[1];
  assign ring_break_o = s_reg.ring_break;
  assign peer_offline_o = s_reg.offline;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_dual_both;
    @(posedge clk_sys_i) disable iff (reset_i)
    (own_go && s_reg.dual) |-> (tx_load == 2'b11) &&
                               (tx_data[0] == tx_data[1]);
  endproperty
  a_dual_both: assert property (p_dual_both)
    else $error("own message not sent on both channels");

  property p_single;
    @(posedge clk_sys_i) disable iff (reset_i)
    !s_reg.dual |-> !tx_load[1] ##1 tx_ch2_o;
  endproperty
  a_single: assert property (p_single)
    else $error("channel two used in single channel mode");

  property p_forward;
    @(posedge clk_sys_i) disable iff (reset_i)
    (rx_peer[0] && !s_reg.fwd_full[0]) |=>
      s_reg.fwd_full[0] && s_reg.fwd_data[0] == $past(rx_data[0]);
  endproperty
  a_forward: assert property (p_forward)
    else $error("peer message not queued for forwarding");

  property p_integrity;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ms_tick && s_reg.integ_ms == 10'(`DRM_INTEGRITY_MS - 1) && !own_go)
      |=> s_reg.own_pend;
  endproperty
  a_integrity: assert property (p_integrity)
    else $error("integrity message not requested");

  property p_change;
    @(posedge clk_sys_i) disable iff (reset_i)
    (apb_wr && drm_hit(paddr_i, `DRM_REG_TXST) &&
     pwdata_i[`DRM_ST_W-1:0] != s_reg.states) |=> s_reg.own_pend;
  endproperty
  a_change: assert property (p_change)
    else $error("state change not queued");

  property p_ring_break;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ms_tick && s_reg.ret_wait && rx_own == 2'b00 &&
     s_reg.ret_ms == 8'(`DRM_RETURN_MS - 1)) |=> s_reg.ring_break;
  endproperty
  a_ring_break: assert property (p_ring_break)
    else $error("missing return did not flag ring break");

  property p_offline_cause;
    @(posedge clk_sys_i) disable iff (reset_i)
    (s_reg.offline & ~$past(s_reg.offline)) != '0 |-> $past(ms_tick);
  endproperty
  a_offline_cause: assert property (p_offline_cause)
    else $error("peer went offline without ageing");

  property p_sender_id;
    @(posedge clk_sys_i) disable iff (reset_i)
    own_go |-> tx_data[0][`DRM_ID_LSB +: `DRM_ID_W] == s_reg.id;
  endproperty
  a_sender_id: assert property (p_sender_id)
    else $error("own message lacks sender identifier");

  property p_rate;
    @(posedge clk_sys_i) disable iff (reset_i)
    tick |=> s_reg.div_cnt == 8'h00 ##1 !tick;
  endproperty
  a_rate: assert property (p_rate)
    else $error("bit tick divider misbehaves");

  property p_own_no_fwd;
    @(posedge clk_sys_i) disable iff (reset_i)
    (rx_own[1] && !s_reg.fwd_full[1] &&
     !(rx_peer[0] && s_reg.bridge)) |=> !s_reg.fwd_full[1];
  endproperty
  a_own_no_fwd: assert property (p_own_no_fwd)
    else $error("own returned message was forwarded");

  property p_bridge;
    @(posedge clk_sys_i) disable iff (reset_i)
    (rx_peer[0] && s_reg.bridge && s_reg.dual && !rx_peer[1] &&
     !s_reg.fwd_full[1]) |=> s_reg.fwd_full[1];
  endproperty
  a_bridge: assert property (p_bridge)
    else $error("channel one message not bridged to channel two");
endmodule
`default_nettype wire

// ===== design/drm_consts.svh
// Constants for the direct ring messaging block
`ifndef DRM_CONSTS_SVH
`define DRM_CONSTS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DRM_CLK_HZ 200000000
`define DRM_OVS 16
`define DRM_RATE_LO_BPS 64000
`define DRM_RATE_HI_BPS 128000
`define DRM_DIV_LO (`DRM_CLK_HZ / (`DRM_RATE_LO_BPS * `DRM_OVS))
`define DRM_DIV_HI (`DRM_CLK_HZ / (`DRM_RATE_HI_BPS * `DRM_OVS))
`define DRM_MS_CYCLES (`DRM_CLK_HZ / 1000)
`define DRM_INTEGRITY_MS 1000
`define DRM_RETURN_MS 20
`define DRM_OFFLINE_MS 2000

// ---------------------------------------------------------------
// Message layout
// ---------------------------------------------------------------
`define DRM_ID_W 4
`define DRM_ST_W 16
`define DRM_SEQ_W 4
`define DRM_MSG_W 24
`define DRM_FRAME_BITS 26
`define DRM_PEERS 16
`define DRM_ID_LSB 20
`define DRM_ST_LSB 4

// ---------------------------------------------------------------
// Register offsets and fields
// ---------------------------------------------------------------
`define DRM_REG_CTRL 8'h00
`define DRM_REG_TXST 8'h04
`define DRM_REG_STAT 8'h08
`define DRM_REG_INTS 8'h0c
`define DRM_REG_INTM 8'h10
`define DRM_REG_RXL 8'h14
`define DRM_CTRL_EN 0
`define DRM_CTRL_DUAL 1
`define DRM_CTRL_RING 2
`define DRM_CTRL_RATE 3
`define DRM_CTRL_BRIDGE 4
`define DRM_CTRL_ID_LSB 8
`define DRM_STAT_RING 0
`define DRM_STAT_OWNP 1
`define DRM_STAT_FWD_LSB 2
`define DRM_STAT_OFF_LSB 16
`define DRM_INT_W 4
`define DRM_INT_RING 0
`define DRM_INT_OFF 1
`define DRM_INT_MSG 2
`define DRM_INT_DROP 3

`endif

// ===== design/drm_pkg.sv
// Types for the direct ring messaging block
`default_nettype none
`include "drm_consts.svh"
package drm_pkg;
  typedef enum logic [0:0] {DRM_TX_IDLE, DRM_TX_SEND} drm_tx_fsm_t;
  typedef enum logic [1:0] {
    DRM_RX_IDLE, DRM_RX_START, DRM_RX_DATA, DRM_RX_STOP
  } drm_rx_fsm_t;
  typedef logic [`DRM_MSG_W-1:0] drm_msg_t;

  typedef struct packed {
    drm_tx_fsm_t fsm;
    logic [3:0] ovs;
    logic [4:0] bits;
    logic [`DRM_FRAME_BITS-1:0] shift;
    logic line;
  } drm_tx_st_t;

  typedef struct packed {
    drm_rx_fsm_t fsm;
    logic [3:0] ovs;
    logic [4:0] bits;
    drm_msg_t shift;
    logic valid;
    drm_msg_t data;
  } drm_rx_st_t;

  typedef struct packed {
    logic en;
    logic dual;
    logic ring;
    logic rate_hi;
    logic bridge;
    logic [`DRM_ID_W-1:0] id;
    logic [`DRM_ST_W-1:0] states;
    logic [`DRM_SEQ_W-1:0] seq;
    logic own_pend;
    logic [1:0] fwd_full;
    logic [1:0][`DRM_MSG_W-1:0] fwd_data;
    logic [7:0] div_cnt;
    logic [17:0] ms_cnt;
    logic [9:0] integ_ms;
    logic ret_wait;
    logic [7:0] ret_ms;
    logic ring_break;
    logic [`DRM_PEERS-1:0][11:0] off_ms;
    logic [`DRM_PEERS-1:0] offline;
    drm_msg_t rx_last;
    logic [`DRM_INT_W-1:0] int_stat;
    logic [`DRM_INT_W-1:0] int_mask;
    logic [31:0] prdata;
  } drm_top_st_t;
endpackage
`default_nettype wire

// ===== design/drm_tx.sv
// Serial frame transmitter for one channel
`timescale 1ns/100ps
`default_nettype none
`include "drm_consts.svh"
module drm_tx (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire drm_pkg::drm_msg_t data_i,
  output logic ready_o,
  output logic line_o
);
  import drm_pkg::*;
  drm_tx_st_t s_reg;
  drm_tx_st_t s_next;

  // ---------------------------------------------------------------
  // Start bit, data LSB first, stop bit
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    case (s_reg.fsm)
      DRM_TX_IDLE: begin
        if (load_i) begin
          s_next.fsm = DRM_TX_SEND;
          s_next.shift = {1'b1, data_i, 1'b0};
          s_next.bits = '0;
          s_next.ovs = '0;
        end
      end
      DRM_TX_SEND: begin
        if (tick_i) begin
          s_next.ovs = s_reg.ovs + 4'h1;
          if (s_reg.ovs == 4'(`DRM_OVS - 1)) begin
            s_next.shift = {1'b1, s_reg.shift[`DRM_FRAME_BITS-1:1]};
            s_next.bits = s_reg.bits + 5'h01;
            if (s_reg.bits == 5'(`DRM_FRAME_BITS - 1)) begin
              s_next.fsm = DRM_TX_IDLE;
            end
          end
        end
      end
      default: begin
        s_next.fsm = DRM_TX_IDLE;
      end
    endcase
    s_next.line = (s_next.fsm == DRM_TX_SEND) ? s_next.shift[0] : 1'b1;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.line <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ready_o = (s_reg.fsm == DRM_TX_IDLE);
  assign line_o = s_reg.line;
endmodule
`default_nettype wire

// ===== design/drm_rx.sv
// Serial frame receiver for one channel
`timescale 1ns/100ps
`default_nettype none
`include "drm_consts.svh"
module drm_rx (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic line_i,
  output logic valid_o,
  output drm_pkg::drm_msg_t data_o
);
  import drm_pkg::*;
  drm_rx_st_t s_reg;
  drm_rx_st_t s_next;

  // ---------------------------------------------------------------
  // Centre sampling on the oversample tick
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    if (tick_i) begin
      s_next.ovs = s_reg.ovs + 4'h1;
      case (s_reg.fsm)
        DRM_RX_IDLE: begin
          s_next.ovs = '0;
          if (!line_i) begin
            s_next.fsm = DRM_RX_START;
          end
        end
        DRM_RX_START: begin
          if (s_reg.ovs == 4'(`DRM_OVS / 2 - 1)) begin
            s_next.ovs = '0;
            s_next.bits = '0;
            s_next.fsm = line_i ? DRM_RX_IDLE : DRM_RX_DATA;
          end
        end
        DRM_RX_DATA: begin
          if (s_reg.ovs == 4'(`DRM_OVS - 1)) begin
            s_next.shift = {line_i, s_reg.shift[`DRM_MSG_W-1:1]};
            s_next.bits = s_reg.bits + 5'h01;
            if (s_reg.bits == 5'(`DRM_MSG_W - 1)) begin
              s_next.fsm = DRM_RX_STOP;
            end
          end
        end
        DRM_RX_STOP: begin
          if (s_reg.ovs == 4'(`DRM_OVS - 1)) begin
            s_next.fsm = DRM_RX_IDLE;
            if (line_i) begin
              s_next.valid = 1'b1;
              s_next.data = s_reg.shift;
            end
          end
        end
        default: begin
          s_next.fsm = DRM_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign valid_o = s_reg.valid;
  assign data_o = s_reg.data;
endmodule
`default_nettype wire

// ===== bench/drm_peer.sv
// Peer relay model driving and watching both serial channels
`timescale 1ns/100ps
`default_nettype none
module drm_peer #(
  parameter int BIT = 1552
) (
  input wire logic clk_sys_i,
  input wire logic [1:0] line_i,
  output logic [1:0] line_o
);
  import drm_pkg::*;
  logic [1:0][23:0] got;
  int n_got [2];
  initial line_o = 2'h3;
  // One bit lasts as long as the node's bit at 128 kbps
  task automatic send(input int k, input drm_msg_t m);
    logic [25:0] f;
    f = {1'b1, m, 1'b0};
    for (int i = 0; i < 26; i++) begin
      @(posedge clk_sys_i);
      line_o[k] <= f[i];
      repeat (BIT - 1) @(posedge clk_sys_i);
    end
  endtask
  // Frame capture: sample each data bit at its centre
  for (genvar k = 0; k < 2; k++) begin : g_rx
    initial n_got[k] = 0;
    always begin
      @(negedge line_i[k]);
      repeat (BIT / 2) @(posedge clk_sys_i);
      for (int i = 0; i < 24; i++) begin
        repeat (BIT) @(posedge clk_sys_i);
        got[k][i] = line_i[k];
      end
      repeat (BIT) @(posedge clk_sys_i);
      n_got[k]++;
    end
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the ring messaging node
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import drm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic pready_o, pslverr_o, irq_o, tx_ch1_o, tx_ch2_o, ring_break_o;
  logic er, bad;
  logic [15:0] peer_offline_o;
  logic [1:0] rxl;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  drm_ring_node #(.MS_TICK_CYCLES(100)) i_drm_ring_node (.clk_sys_i,
    .reset_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .irq_o, .tx_ch1_o, .tx_ch2_o,
    .rx_ch1_i(rxl[0]), .rx_ch2_i(rxl[1]), .ring_break_o, .peer_offline_o);
  drm_peer i_drm_peer (.clk_sys_i(clk_sys_i),
    .line_i({tx_ch2_o, tx_ch1_o}), .line_o(rxl));
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task give_verdict;
    $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard: the run needs about 85000 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 99000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk("status", rd, 32'hfffe0000);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'(er), 32'h1);
    $display("Test reset values done");
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h00, 32'h51f);
    apb(1'b1, 8'h04, 32'ha5a5);
    fork
      begin
        repeat (200) @(posedge clk_sys_i);
        i_drm_peer.send(0, 24'h312347);
      end
      wait (i_drm_peer.n_got[0] > 0 && i_drm_peer.n_got[1] > 0);
    join
    chk("own ch1", 32'(i_drm_peer.got[0][23:4]), 32'h5a5a5);
    chk("own ch2", 32'(i_drm_peer.got[1][23:4]), 32'h5a5a5);
    repeat (20) @(posedge clk_sys_i);
    chk("peer online", 32'(peer_offline_o[3]), 32'h0);
    chk("ring break", 32'(ring_break_o), 32'h1);
    chk("irq raised", 32'(irq_o), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("rx last", rd, 32'h312347);
    apb(1'b1, 8'h0c, 32'h4);
    repeat (2) @(posedge clk_sys_i);
    chk("irq cleared", 32'(irq_o), 32'h0);
    $display("Test own and peer frames done");
    fork
      i_drm_peer.send(1, 24'h5a5a50);
      wait (i_drm_peer.n_got[0] > 1 && i_drm_peer.n_got[1] > 1);
    join
    chk("fwd ch1", 32'(i_drm_peer.got[0]), 32'h312347);
    chk("bridge ch2", 32'(i_drm_peer.got[1]), 32'h312347);
    repeat (20) @(posedge clk_sys_i);
    chk("ring restored", 32'(ring_break_o), 32'h0);
    bad = 1'b0;
    repeat (3200) begin
      @(posedge clk_sys_i);
      if ((tx_ch1_o & tx_ch2_o) !== 1'b1)
        bad = 1'b1;
    end
    chk("own not forwarded", 32'(bad), 32'h0);
    $display("Test forwarding done");
    give_verdict;
  end
endmodule
`default_nettype wire
